/* File: hw/dmr_device.sv */
// DRAM die end: stores the base and aux mode registers, orders bursts,
// runs latency, DLL lock, termination and drive selection.
// Assumes the controller end keeps its own timing and spacing duties.
module dmr_device
  import dmr_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             resetn,
  dmr_link_if.device            link,
  input  wire logic [3:0]       write_term_div,
  output logic                  dll_active,
  output logic                  dll_locked,
  output logic                  pd_dll_on,
  output logic                  out_disabled,
  output logic [3:0]            drive_div,
  output logic [3:0]            term_div,
  output logic [LAT_W-1:0]      read_latency,
  output logic [LAT_W-1:0]      write_latency,
  output logic [3:0]            write_recovery
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_BURST = 3'b100
  } dmr_dev_state_type;

  logic [AW-1:0]     base_reg, base_next, aux_reg, aux_next;
  logic [LOCK_W-1:0] lock_reg, lock_next;
  logic              sr_reg, sr_next;
  dmr_dev_state_type st_reg, st_next;
  logic [LAT_W-1:0]  cnt_reg, cnt_next;
  logic [2:0]        beat_reg, beat_next;
  logic [COL_W-1:0]  col_reg, col_next;
  logic              wr_reg, wr_next, chop_reg, chop_next;
  logic [DQ_W-1:0]   mem [MEM_WORDS];
  logic              mem_we;
  logic [COL_W-1:0]  mem_wa;
  logic              emit;
  logic [2:0]        emit_idx;
  logic [DQ_W-1:0]   dq_next;
  logic              oe_next, dqs_next;
  logic [LAT_W-1:0]  rl, wl;
  logic [2:0]        rtt_code;
  logic [3:0]        nom_div, term_next, drive_next;
  logic              dll_next;

  // Column address of beat i of a read burst.
  function automatic logic [2:0] beat_col(input logic [2:0] c, input logic [2:0] i,
                                          input logic il);
    beat_col[2]   = c[2] ^ i[2];
    beat_col[1:0] = il ? (c[1:0] ^ i[1:0]) : (c[1:0] + i[1:0]);
  endfunction : beat_col

  assign rl = dmr_read_lat(base_reg, aux_reg);
  assign wl = dmr_write_lat(base_reg, aux_reg);

  // Mode register loads, DLL reset and self-refresh tracking.
  always_comb begin
    base_next = base_reg;
    aux_next  = aux_reg;
    sr_next   = sr_reg;
    lock_next = lock_reg;
    if (lock_reg != '0 && link.cke) begin
      lock_next = lock_reg - 10'h001;
    end
    if (link.cmd == CMD_MRS && link.ba == BA_BASE) begin
      base_next = link.addr;
      base_next[DLLRST_BIT] = 1'b0;
      if (link.addr[DLLRST_BIT]) begin
        lock_next = LOCK_W'(DLL_LOCK_CYC);
      end
    end else if (link.cmd == CMD_MRS && link.ba == BA_AUX) begin
      aux_next = link.addr;
    end else if (link.cmd == CMD_SRE) begin
      sr_next = 1'b1;
    end else if (link.cmd == CMD_SRX) begin
      sr_next = 1'b0;
      if (!aux_reg[DLL_DIS_BIT]) begin
        lock_next = LOCK_W'(DLL_LOCK_CYC);
      end
    end
  end

  // Burst sequencer: latency wait, then eight beat slots.
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    beat_next = beat_reg;
    col_next  = col_reg;
    wr_next   = wr_reg;
    chop_next = chop_reg;
    mem_we    = 1'b0;
    mem_wa    = {col_reg[COL_W-1:3], beat_reg};
    emit      = 1'b0;
    emit_idx  = 3'h0;
    case (st_reg)
      ST_IDLE: begin
        if (link.cmd == CMD_READ || link.cmd == CMD_WRITE) begin
          wr_next   = (link.cmd == CMD_WRITE);
          col_next  = link.addr[COL_W-1:0];
          chop_next = (base_reg[BL_LSB+:2] == BL_CHOP4) ||
                      (base_reg[BL_LSB+:2] == BL_OTF && !link.addr[OTF_BIT]);
          cnt_next  = (link.cmd == CMD_WRITE) ? wl : rl;
          st_next   = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cnt_reg == 6'h01) begin
          st_next   = ST_BURST;
          beat_next = 3'h0;
          emit      = !wr_reg;
        end else begin
          cnt_next = cnt_reg - 6'h01;
        end
      end
      ST_BURST: begin
        beat_next = beat_reg + 3'h1;
        if (wr_reg) begin
          mem_we = !(chop_reg && beat_reg[2]);
          mem_wa = chop_reg ? {col_reg[COL_W-1:2], beat_reg[1:0]}
                            : {col_reg[COL_W-1:3], beat_reg};
        end
        if (beat_reg == 3'h7) begin
          st_next = ST_IDLE;
        end else begin
          emit     = !wr_reg;
          emit_idx = beat_reg + 3'h1;
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  // Read data, strobe and their enables for the next cycle.
  always_comb begin
    dq_next  = mem[{col_reg[COL_W-1:3], beat_col(col_reg[2:0], emit_idx, base_reg[BT_BIT])}];
    oe_next  = emit && !(chop_reg && emit_idx[2])
               && !aux_reg[QOFF_BIT];
    dqs_next = emit_idx[0];
  end

  // Drive, termination and status decode.
  always_comb begin
    dll_next = !aux_reg[DLL_DIS_BIT] && !sr_reg;
    case ({aux_reg[DRV_HI_BIT], aux_reg[DRV_LO_BIT]})
      2'h0:    drive_next = 4'h6;
      2'h1:    drive_next = 4'h7;
      default: drive_next = 4'h0;
    endcase
    rtt_code = {aux_reg[RTT_B2_BIT], aux_reg[RTT_B1_BIT], aux_reg[RTT_B0_BIT]};
    case (rtt_code)
      3'h1:    nom_div = 4'h4;
      3'h2:    nom_div = 4'h2;
      3'h3:    nom_div = 4'h6;
      3'h4:    nom_div = 4'hc;
      3'h5:    nom_div = 4'h8;
      default: nom_div = 4'h0;
    endcase
    if (aux_reg[LVL_BIT] && !aux_reg[QOFF_BIT] && rtt_code > 3'h3) begin
      nom_div = 4'h0;
    end
    if (!link.odt || (st_reg != ST_IDLE && !wr_reg)) begin
      term_next = 4'h0;
    end else if (st_reg == ST_BURST && wr_reg && write_term_div != 4'h0) begin
      term_next = write_term_div;
    end else begin
      term_next = nom_div;
    end
  end

  // State registers.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      base_reg       <= BASE_RESET;
      aux_reg        <= AUX_RESET;
      lock_reg       <= '0;
      sr_reg         <= 1'b0;
      st_reg         <= ST_IDLE;
      cnt_reg        <= '0;
      beat_reg       <= '0;
      col_reg        <= '0;
      wr_reg         <= 1'b0;
      chop_reg       <= 1'b0;
      link.dq_d      <= '0;
      link.dq_d_oe   <= 1'b0;
      link.dqs_d     <= 1'b0;
      link.dqs_d_oe  <= 1'b0;
      dll_active     <= 1'b0;
      dll_locked     <= 1'b0;
      pd_dll_on      <= 1'b0;
      out_disabled   <= 1'b0;
      drive_div      <= '0;
      term_div       <= '0;
      read_latency   <= '0;
      write_latency  <= '0;
      write_recovery <= '0;
    end else begin
      base_reg       <= base_next;
      aux_reg        <= aux_next;
      lock_reg       <= lock_next;
      sr_reg         <= sr_next;
      st_reg         <= st_next;
      cnt_reg        <= cnt_next;
      beat_reg       <= beat_next;
      col_reg        <= col_next;
      wr_reg         <= wr_next;
      chop_reg       <= chop_next;
      link.dq_d      <= dq_next;
      link.dq_d_oe   <= oe_next;
      link.dqs_d     <= dqs_next;
      link.dqs_d_oe  <= oe_next;
      dll_active     <= dll_next;
      dll_locked     <= dll_next && lock_reg == '0;
      pd_dll_on      <= base_reg[PD_BIT];
      out_disabled   <= aux_reg[QOFF_BIT];
      drive_div      <= drive_next;
      term_div       <= term_next;
      read_latency   <= rl;
      write_latency  <= wl;
      write_recovery <= {1'b0, base_reg[WR_LSB+:3]};
    end
  end

  // Data array; it holds no control state and needs no reset.
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[mem_wa] <= link.dq;
    end
  end
endmodule : dmr_device

/* File: hw/dmr_pkg.sv */
// Shared constants, types and latency decode for the mode-register link.
// Assumes one 250 MHz clock shared by both ends and one beat per clock.
package dmr_pkg;
  // Clock and data geometry.
  localparam int TCK_PS    = 4000;
  localparam int DQ_W      = 8;
  localparam int AW        = 16;
  localparam int COL_W     = 6;
  localparam int MEM_WORDS = 64;
  localparam int BEATS     = 8;
  localparam int LAT_W     = 6;
  localparam int LOCK_W    = 10;

  // Commands on the link.
  typedef enum logic [2:0] {
    CMD_NOP   = 3'h0,
    CMD_MRS   = 3'h1,
    CMD_READ  = 3'h2,
    CMD_WRITE = 3'h3,
    CMD_SRE   = 3'h4,
    CMD_SRX   = 3'h5
  } dmr_cmd_type;

  // Register selects on the bank pins.
  localparam logic [2:0] BA_BASE = 3'h0;
  localparam logic [2:0] BA_AUX  = 3'h1;

  // Base mode register fields.
  localparam int BL_LSB     = 0;
  localparam int CL_EXT_BIT = 2;
  localparam int BT_BIT     = 3;
  localparam int CL_LSB     = 4;
  localparam int DLLRST_BIT = 8;
  localparam int WR_LSB     = 9;
  localparam int PD_BIT     = 12;
  localparam int OTF_BIT    = 12;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_CHOP4  = 2'h2;

  // Aux mode register fields.
  localparam int DLL_DIS_BIT = 0;
  localparam int DRV_LO_BIT  = 1;
  localparam int RTT_B0_BIT  = 2;
  localparam int AL_LSB      = 3;
  localparam int DRV_HI_BIT  = 5;
  localparam int RTT_B1_BIT  = 6;
  localparam int LVL_BIT     = 7;
  localparam int RTT_B2_BIT  = 9;
  localparam int QOFF_BIT    = 12;
  localparam logic [AW-1:0] AUX_RSVD_MASK = 16'he500;

  // Values after reset.
  localparam logic [AW-1:0] BASE_RESET = 16'h0000;
  localparam logic [AW-1:0] AUX_RESET  = 16'h0000;

  // Latency figures.
  localparam int CL_BASE      = 4;
  localparam int CWL_CYC      = 5;
  localparam logic [3:0] DLL_OFF_CL_CODE = 4'h2;

  // Times and derived cycle counts.
  localparam int DLL_LOCK_CYC = 512;
  localparam int TMRD_CYC     = 4;
  localparam int TMOD_CYC     = 12;
  localparam int TWR_PS       = 15000;
  localparam int WR_MIN       = 5;
  localparam int WR_RAW       = (TWR_PS + TCK_PS - 1) / TCK_PS;
  localparam int WR_CYC       = (WR_RAW < WR_MIN) ? WR_MIN : WR_RAW;
  localparam logic [2:0] WR_CODE =
    3'((WR_CYC <= 8) ? WR_CYC - 4 : (WR_CYC <= 10) ? 5 : 6);
  localparam int TXP_PS       = 6000;
  localparam int SLOW_EXIT_DELAY_PS    = 24000;
  localparam int TXP_CYC      = (TXP_PS + TCK_PS - 1) / TCK_PS;
  localparam int SLOW_EXIT_DELAY_CYC   = (SLOW_EXIT_DELAY_PS + TCK_PS - 1) / TCK_PS;

  // Read latency is additive latency plus read cas latency.
  function automatic logic [LAT_W-1:0] dmr_read_lat(input logic [AW-1:0] base,
                                                    input logic [AW-1:0] aux);
    logic [LAT_W-1:0] cl;
    cl = LAT_W'(CL_BASE) + LAT_W'({base[CL_EXT_BIT], base[CL_LSB+:3]});
    case (aux[AL_LSB+:2])
      2'h1:    dmr_read_lat = cl + cl - 6'h01;
      2'h2:    dmr_read_lat = cl + cl - 6'h02;
      default: dmr_read_lat = cl;
    endcase
  endfunction : dmr_read_lat

  // Write latency is additive latency plus write cas latency.
  function automatic logic [LAT_W-1:0] dmr_write_lat(input logic [AW-1:0] base,
                                                     input logic [AW-1:0] aux);
    logic [LAT_W-1:0] cl;
    cl = LAT_W'(CL_BASE) + LAT_W'({base[CL_EXT_BIT], base[CL_LSB+:3]});
    case (aux[AL_LSB+:2])
      2'h1:    dmr_write_lat = cl - 6'h01 + LAT_W'(CWL_CYC);
      2'h2:    dmr_write_lat = cl - 6'h02 + LAT_W'(CWL_CYC);
      default: dmr_write_lat = LAT_W'(CWL_CYC);
    endcase
  endfunction : dmr_write_lat
endpackage : dmr_pkg

/* File: hw/dmr_link_if.sv */
// Link between the controller end and the DRAM die end.
// Assumes both ends share mclk; the shared data wire is resolved here.
interface dmr_link_if;
  import dmr_pkg::*;
  logic              cke;
  dmr_cmd_type       cmd;
  logic [2:0]        ba;
  logic [AW-1:0]     addr;
  logic              odt;
  logic [DQ_W-1:0]   dq_c;
  logic              dq_c_oe;
  logic [DQ_W-1:0]   dq_d;
  logic              dq_d_oe;
  logic              dqs_d;
  logic              dqs_d_oe;
  logic [DQ_W-1:0]   dq;

  // Level on the data wire; an undriven wire reads as zero.
  assign dq = dq_d_oe ? dq_d : (dq_c_oe ? dq_c : '0);

  modport device (input cke, cmd, ba, addr, odt, dq,
                  output dq_d, dq_d_oe, dqs_d, dqs_d_oe);
  modport controller (output cke, cmd, ba, addr, odt, dq_c, dq_c_oe,
                      input dq, dqs_d_oe);
endinterface : dmr_link_if

/* File: hw/dmr_controller.sv */
// Controller end: issues load-mode, read, write and self-refresh commands
// and keeps the spacing, lock wait and field rules of the link.
// Assumes the die end decodes the fields that this end places on the link.
module dmr_controller
  import dmr_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              resetn,
  dmr_link_if.controller         link,
  input  wire logic              req_valid,
  input  dmr_cmd_type            req_kind,
  input  wire logic [2:0]        req_ba,
  input  wire logic [AW-1:0]     req_addr,
  input  wire logic [63:0]       req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [63:0]            rsp_rdata
);
  typedef enum logic [2:0] {
    CS_IDLE = 3'b001,
    CS_WAIT = 3'b010,
    CS_DATA = 3'b100
  } dmr_ctl_state_type;

  dmr_ctl_state_type st_reg, st_next;
  dmr_cmd_type       kind_reg, kind_next, cmd_next;
  logic [LAT_W-1:0]  cnt_reg, cnt_next;
  logic [2:0]        idx_reg, idx_next;
  logic [AW-1:0]     base_reg, base_next, aux_reg, aux_next, a, addr_next;
  logic [LOCK_W-1:0] lockw_reg, lockw_next;
  logic              pend_reg, pend_next;
  logic [63:0]       wdata_reg, wdata_next, rdata_next;
  logic [2:0]        ba_next;
  logic [DQ_W-1:0]   dq_next;
  logic              oe_next, rsp_next, ready_next, odt_next;

  // Command issue, shadow registers and data phases.
  always_comb begin
    st_next    = st_reg;
    kind_next  = kind_reg;
    cnt_next   = cnt_reg;
    idx_next   = idx_reg;
    base_next  = base_reg;
    aux_next   = aux_reg;
    pend_next  = pend_reg;
    wdata_next = wdata_reg;
    rdata_next = rsp_rdata;
    lockw_next = (lockw_reg != '0) ? lockw_reg - 10'h001 : lockw_reg;
    cmd_next   = CMD_NOP;
    ba_next    = link.ba;
    addr_next  = link.addr;
    dq_next    = link.dq_c;
    oe_next    = 1'b0;
    rsp_next   = 1'b0;
    a          = req_addr;
    case (st_reg)
      CS_IDLE: begin
        if (req_valid && req_ready) begin
          cmd_next  = req_kind;
          ba_next   = req_ba;
          kind_next = req_kind;
          st_next   = CS_WAIT;
          cnt_next  = LAT_W'(TMRD_CYC);
          case (req_kind)
            CMD_MRS: begin
              cnt_next = LAT_W'(TMOD_CYC);
              if (req_ba == BA_BASE) begin
                a[WR_LSB+:3] = WR_CODE;
                if (aux_reg[DLL_DIS_BIT]) begin
                  {a[CL_EXT_BIT], a[CL_LSB+:3]} = DLL_OFF_CL_CODE;
                end
                if (pend_reg) begin
                  a[DLLRST_BIT] = 1'b1;
                end
                if (a[DLLRST_BIT]) begin
                  lockw_next = LOCK_W'(DLL_LOCK_CYC);
                  pend_next  = 1'b0;
                end
                base_next = a;
              end else if (req_ba == BA_AUX) begin
                a = req_addr & ~AUX_RSVD_MASK;
                if (!a[DLL_DIS_BIT]) begin
                  pend_next = 1'b1;
                end
                aux_next = a;
              end
              addr_next = a;
            end
            CMD_READ: begin
              cnt_next   = dmr_read_lat(base_reg, aux_reg) + LAT_W'(BEATS + 1);
              idx_next   = 3'h0;
              rdata_next = '0;
              addr_next  = req_addr;
            end
            CMD_WRITE: begin
              cnt_next   = dmr_write_lat(base_reg, aux_reg);
              wdata_next = req_wdata;
              addr_next  = req_addr;
            end
            CMD_SRX: begin
              cnt_next = base_reg[PD_BIT] ? LAT_W'(TXP_CYC) : LAT_W'(SLOW_EXIT_DELAY_CYC);
              if (!aux_reg[DLL_DIS_BIT]) begin
                lockw_next = LOCK_W'(DLL_LOCK_CYC);
              end
            end
            default: cnt_next = LAT_W'(TMRD_CYC);
          endcase
        end
      end
      CS_WAIT: begin
        if (kind_reg == CMD_READ && link.dqs_d_oe) begin
          rdata_next[idx_reg*DQ_W +: DQ_W] = link.dq;
          idx_next = idx_reg + 3'h1;
        end
        if (cnt_reg == '0) begin
          if (kind_reg == CMD_WRITE) begin
            dq_next  = wdata_reg[DQ_W-1:0];
            oe_next  = 1'b1;
            idx_next = 3'h1;
            st_next  = CS_DATA;
          end else begin
            rsp_next = (kind_reg == CMD_READ);
            st_next  = CS_IDLE;
          end
        end else begin
          cnt_next = cnt_reg - 6'h01;
        end
      end
      CS_DATA: begin
        if (idx_reg == 3'h0) begin
          st_next = CS_IDLE;
        end else begin
          dq_next  = wdata_reg[idx_reg*DQ_W +: DQ_W];
          oe_next  = 1'b1;
          idx_next = idx_reg + 3'h1;
        end
      end
      default: st_next = CS_IDLE;
    endcase
    ready_next = (st_next == CS_IDLE) && (lockw_next == '0);
    odt_next = ({aux_next[RTT_B2_BIT], aux_next[RTT_B1_BIT], aux_next[RTT_B0_BIT]} != 3'h0)
               && !aux_next[DLL_DIS_BIT]
               && !(st_next != CS_IDLE && (kind_next == CMD_READ || kind_next == CMD_MRS));
  end

  // State registers; the clock enable is low in reset and goes high on the first edge after it.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_reg       <= CS_IDLE;
      kind_reg     <= CMD_NOP;
      cnt_reg      <= '0;
      idx_reg      <= '0;
      base_reg     <= BASE_RESET;
      aux_reg      <= AUX_RESET;
      lockw_reg    <= '0;
      pend_reg     <= 1'b0;
      wdata_reg    <= '0;
      link.cke     <= 1'b0;
      link.cmd     <= CMD_NOP;
      link.ba      <= '0;
      link.addr    <= '0;
      link.odt     <= 1'b0;
      link.dq_c    <= '0;
      link.dq_c_oe <= 1'b0;
      req_ready    <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_rdata    <= '0;
    end else begin
      st_reg       <= st_next;
      kind_reg     <= kind_next;
      cnt_reg      <= cnt_next;
      idx_reg      <= idx_next;
      base_reg     <= base_next;
      aux_reg      <= aux_next;
      lockw_reg    <= lockw_next;
      pend_reg     <= pend_next;
      wdata_reg    <= wdata_next;
      link.cke     <= 1'b1;
      link.cmd     <= cmd_next;
      link.ba      <= ba_next;
      link.addr    <= addr_next;
      link.odt     <= odt_next;
      link.dq_c    <= dq_next;
      link.dq_c_oe <= oe_next;
      req_ready    <= ready_next;
      rsp_valid    <= rsp_next;
      rsp_rdata    <= rdata_next;
    end
  end
endmodule : dmr_controller

/* File: dv/dmr_link_assertions.sv */
// Checker of the link signals between the two ends.
// Assumes it sees the signals of one dmr_link_if on the shared clock.
module dmr_link_assertions
  import dmr_pkg::*;
(
  input wire logic          mclk,
  input wire logic          resetn,
  input dmr_cmd_type        cmd,
  input wire logic [2:0]    ba,
  input wire logic [AW-1:0] addr,
  input wire logic          odt,
  input wire logic          dq_d_oe,
  input wire logic          dqs_d_oe
);
  logic [LOCK_W-1:0] lock_reg;
  logic [LOCK_W-1:0] lock_next;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Counts down the lock wait; a loop reset reloads it.
  always_comb begin
    lock_next = (lock_reg != '0) ? lock_reg - 10'h001 : lock_reg;
    if (cmd == CMD_MRS && ba == BA_BASE && addr[DLLRST_BIT]) lock_next = LOCK_W'(DLL_LOCK_CYC);
  end
  // Holds the count.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) lock_reg <= '0;
    else lock_reg <= lock_next;
  end
  property p_lock_wait; cmd == CMD_READ |-> lock_reg == '0; endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("read too soon");
  property p_rsvd; cmd == CMD_MRS && ba == BA_AUX |-> (addr & AUX_RSVD_MASK) == '0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_wr; cmd == CMD_MRS && ba == BA_BASE |-> addr[WR_LSB+:3] == WR_CODE; endproperty
  a_wr: assert property (p_wr) else $error("bad write recovery");
  property p_strobe; dqs_d_oe == dq_d_oe; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe enable differs");
  property p_read_odt; cmd == CMD_READ |-> !odt; endproperty
  a_read_odt: assert property (p_read_odt) else $error("odt high at read");
  property p_burst_odt; dq_d_oe |-> !odt; endproperty
  a_burst_odt: assert property (p_burst_odt) else $error("odt high in burst");
  property p_read_lat; cmd == CMD_READ |=> !dq_d_oe [*4]; endproperty
  a_read_lat: assert property (p_read_lat) else $error("data too early");
  property p_mrs_gap; cmd == CMD_MRS |=> (cmd != CMD_MRS) [*3]; endproperty
  a_mrs_gap: assert property (p_mrs_gap) else $error("load-mode too close");
  property p_beats; $rose(dq_d_oe) |-> dq_d_oe [*4] ##1 (!dq_d_oe || dq_d_oe [*4]); endproperty
  a_beats: assert property (p_beats) else $error("burst too short");
endmodule : dmr_link_assertions

/* File: dv/ddr3_mode_reg_zero_one_config_tb.sv */
// Bench joining the controller end and the die end over one link.
// Assumes the package, interface, both ends and the checker are compiled.
module ddr3_mode_reg_zero_one_config_tb
  import dmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             mclk = 1'b0;
  logic             resetn = 1'b0;
  logic             req_valid = 1'b0;
  dmr_cmd_type      req_kind = CMD_NOP;
  logic [2:0]       req_ba = 3'h0;
  logic [AW-1:0]    req_addr = '0;
  logic [63:0]      req_wdata = '0;
  logic [3:0]       write_term_div = 4'h3;
  logic             req_ready, rsp_valid, dll_active, dll_locked, pd_dll_on, out_disabled;
  logic [63:0]      rsp_rdata;
  logic [3:0]       drive_div, write_recovery, term_div;
  logic [LAT_W-1:0] read_latency, write_latency;
  int               failures = 0;
  int               checks = 0;
  int               cycles = 0;
  // Rows: base, aux, read latency, write latency, drive divisor, power-down flag.
  localparam logic [63:0] ROWS [3] = '{64'h0010_0000_0505_0600,
    64'h0024_000a_1b12_0700, 64'h1040_0010_0e0b_0601};
  dmr_link_if u_dmr_link_if ();
  dmr_controller u_dmr_controller (.mclk(mclk), .resetn(resetn), .link(u_dmr_link_if),
    .req_valid(req_valid), .req_kind(req_kind), .req_ba(req_ba), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));
  dmr_device u_dmr_device (.mclk(mclk), .resetn(resetn), .link(u_dmr_link_if),
    .write_term_div(write_term_div), .dll_active(dll_active), .dll_locked(dll_locked),
    .pd_dll_on(pd_dll_on), .out_disabled(out_disabled), .drive_div(drive_div),
    .term_div(term_div), .read_latency(read_latency), .write_latency(write_latency),
    .write_recovery(write_recovery));
  dmr_link_assertions u_dmr_link_assertions (.mclk(mclk), .resetn(resetn),
    .cmd(u_dmr_link_if.cmd), .ba(u_dmr_link_if.ba), .addr(u_dmr_link_if.addr),
    .odt(u_dmr_link_if.odt), .dq_d_oe(u_dmr_link_if.dq_d_oe),
    .dqs_d_oe(u_dmr_link_if.dqs_d_oe));
  // Compares one value and counts it.
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Holds one request until it is taken, then lets an edge pass.
  task automatic send(input dmr_cmd_type k, input logic [2:0] b, input logic [AW-1:0] a,
                      input logic [63:0] w);
    req_valid <= 1'b1;
    req_kind <= k;
    req_ba <= b;
    req_addr <= a;
    req_wdata <= w;
    do @(posedge mclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    @(posedge mclk);
  endtask : send
  // Reads one burst and compares the word returned.
  task automatic rd(input logic [AW-1:0] a, input logic [63:0] e);
    send(CMD_READ, 3'h0, a, '0);
    do @(posedge mclk); while (rsp_valid !== 1'b1);
    chk("rdata", rsp_rdata, e);
  endtask : rd
  // Waits until the controller is free again.
  task automatic idle();
    do @(posedge mclk); while (req_ready !== 1'b1);
  endtask : idle
  // Prints the verdict and ends the run.
  task automatic summarize();
    if (failures == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  // Makes the clock.
  initial forever #2 mclk = ~mclk;
  // Cuts a hung run short.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      summarize();
    end
  end
  // Main sequence: reset, table rows, burst orders, output disable, reset again.
  initial begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("read_latency", 64'(read_latency), 64'h4);
    chk("drive_div", 64'(drive_div), 64'h6);
    for (int i = 0; i < 3; i++) begin
      send(CMD_MRS, BA_AUX, ROWS[i][47:32], '0);
      send(CMD_MRS, BA_BASE, ROWS[i][63:48], '0);
      repeat (20) @(posedge mclk);
      chk("dll_locked", 64'(dll_locked), 64'h0);
      idle();
      // The die's lock flag trails the controller's wait by two edges.
      repeat (2) @(posedge mclk);
      chk("dll_locked", 64'(dll_locked), 64'h1);
      chk("read_latency", 64'(read_latency), 64'(ROWS[i][31:24]));
      chk("write_latency", 64'(write_latency), 64'(ROWS[i][23:16]));
      chk("drive_div", 64'(drive_div), 64'(ROWS[i][15:8]));
      chk("pd_dll_on", 64'(pd_dll_on), 64'(ROWS[i][7:0]));
      chk("write_recovery", 64'(write_recovery), 64'(WR_CODE));
    end
    send(CMD_MRS, BA_AUX, 16'h0000, '0);
    send(CMD_MRS, BA_BASE, 16'h0018, '0);
    send(CMD_WRITE, 3'h0, 16'h0005, 64'h0706050403020100);
    rd(16'h0005, 64'h0203000106070405);
    send(CMD_MRS, BA_BASE, 16'h0010, '0);
    rd(16'h0005, 64'h0003020104070605);
    send(CMD_MRS, BA_BASE, 16'h0011, '0);
    send(CMD_WRITE, 3'h0, 16'h0006, 64'hffffffff1b1a1918);
    rd(16'h1000, 64'h1b1a191803020100);
    rd(16'h0007, 64'h000000001a19181b);
    send(CMD_MRS, BA_AUX, 16'h1000, '0);
    idle();
    chk("out_disabled", 64'(out_disabled), 64'h1);
    rd(16'h1000, 64'h0);
    // Nominal termination in idle, then a read with termination enabled.
    send(CMD_MRS, BA_AUX, 16'h0044, '0);
    idle();
    repeat (2) @(posedge mclk);
    chk("term_div", 64'(term_div), 64'h6);
    rd(16'h1000, 64'h1b1a191803020100);
    // Self-refresh stops the loop; exit restarts it and waits for lock.
    send(CMD_SRE, 3'h0, 16'h0000, '0);
    idle();
    chk("dll_active", 64'(dll_active), 64'h0);
    send(CMD_SRX, 3'h0, 16'h0000, '0);
    repeat (2) @(posedge mclk);
    chk("dll_active", 64'(dll_active), 64'h1);
    chk("dll_locked", 64'(dll_locked), 64'h0);
    idle();
    repeat (2) @(posedge mclk);
    chk("dll_locked", 64'(dll_locked), 64'h1);
    // Loop disabled: latency forced to six, no termination, fixed chop.
    send(CMD_MRS, BA_AUX, 16'h0001, '0);
    send(CMD_MRS, BA_BASE, 16'h0012, '0);
    idle();
    chk("read_latency", 64'(read_latency), 64'h6);
    chk("dll_active", 64'(dll_active), 64'h0);
    chk("term_div", 64'(term_div), 64'h0);
    rd(16'h0004, 64'h000000001b1a1918);
    resetn <= 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("out_disabled", 64'(out_disabled), 64'h0);
    chk("read_latency", 64'(read_latency), 64'h4);
    summarize();
  end
endmodule : ddr3_mode_reg_zero_one_config_tb
